// ===== pkg/fosr_pkg.sv
// Package of constants and types for the flash operation status register.
package fosr_pkg;

    localparam int unsigned DATA_W = 16;
    localparam int unsigned SR_W = 8;
    localparam int unsigned BANK_W = 4;

    // Bit positions within the status byte.
    localparam int unsigned BIT_READY = 7;
    localparam int unsigned BIT_ESUSP = 6;
    localparam int unsigned BIT_ECHK = 5;
    localparam int unsigned BIT_PERR = 4;
    localparam int unsigned BIT_SUPPLY = 3;
    localparam int unsigned BIT_PSUSP = 2;
    localparam int unsigned BIT_PROT = 1;
    localparam int unsigned BIT_BANKW = 0;

    localparam logic [3:0] ERR_RESET = 4'h0;
    localparam logic [1:0] SYNC_RESET = 2'h3;
    localparam logic [15:0] DOUT_RESET = 16'h0000;

    // Operation kinds started by the command decoder.
    typedef enum logic [1:0] {
        FOSR_OP_PROGRAM,
        FOSR_OP_ERASE,
        FOSR_OP_BLANK,
        FOSR_OP_FACTORY
    } fosr_op_e;

    // Controller activity as seen by the status logic.
    typedef enum logic [2:0] {
        FOSR_IDLE,
        FOSR_RUN,
        FOSR_SUSPENDING,
        FOSR_SUSPENDED
    } fosr_ctl_e;

    // Operation start request from the command decoder.
    typedef struct packed {
        logic             start;
        fosr_op_e         op;
        logic [BANK_W-1:0] bank;
        logic             blockLocked;
    } fosr_start_s;

    // Completion and fault report from the array engine.
    typedef struct packed {
        logic done;
        logic pulseFail;
        logic notBlank;
        logic oneOverZero;
        logic paused;
        logic bufferBusy;
    } fosr_engine_s;

endpackage

// ===== hw/fosr_error_flags.sv
// Sticky error flags with set over clear priority.
`timescale 1ns/100ps
module fosr_error_flags
    import fosr_pkg::*;
#(
    parameter int unsigned WIDTH = 4
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] setFlag,
    input  wire logic             clearAll,
    output logic      [WIDTH-1:0] flag_r
);

    initial begin
        if (WIDTH < 1) begin
            $error("WIDTH must be at least one.");
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            flag_r <= WIDTH'(ERR_RESET);
        end else begin
            flag_r <= setFlag | (clearAll ? '0 : flag_r);
        end
    end

    a_sticky_hold: assert property (@(posedge clk) disable iff (!resetn)
        !$past(clearAll) |-> ((flag_r & $past(flag_r)) == $past(flag_r)))
        else $error("Error flag dropped without a clear.");

endmodule

// ===== hw/fosr_status_reg.sv
// Status register of the program/erase controller on the flash bus.
`timescale 1ns/100ps
module fosr_status_reg
    import fosr_pkg::*;
#(
    parameter int unsigned BANKS = 16
) (
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire logic              chipEnableN,
    input  wire logic              outputEnableN,
    input  wire logic [BANK_W-1:0] readBank,
    input  wire logic              readArrayMode,
    input  wire logic              supplyValid,
    input  wire logic              clearStatus,
    input  wire logic              suspendCmd,
    input  wire logic              resumeCmd,
    input  wire fosr_start_s       startReq,
    input  wire fosr_engine_s      engine,
    input  wire logic [DATA_W-1:0] arrayData,
    output logic      [DATA_W-1:0] dataOut_r,
    output logic                   statusSelected,
    output logic                   opAccepted,
    output logic                   opAbort,
    output logic      [SR_W-1:0]   statusNow
);

    initial begin
        if (BANKS < 1 || BANKS > (1 << BANK_W)) begin
            $error("BANKS does not fit the bank field.");
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.

    logic [1:0] ceSync_r;
    logic [1:0] oeSync_r;
    logic [1:0] vppSync_r;
    logic       strobeN;
    logic       strobeN_r;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            ceSync_r  <= SYNC_RESET;
            oeSync_r  <= SYNC_RESET;
            vppSync_r <= '0;
        end else begin
            ceSync_r  <= {ceSync_r[0], chipEnableN};
            oeSync_r  <= {oeSync_r[0], outputEnableN};
            vppSync_r <= {vppSync_r[0], supplyValid};
        end
    end

    assign strobeN = ceSync_r[1] | oeSync_r[1];

    always_ff @(posedge clk) begin
        if (!resetn) begin
            strobeN_r <= 1'b1;
        end else begin
            strobeN_r <= strobeN;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Controller state.

    fosr_ctl_e         ctl_r;
    fosr_op_e          op_r;
    logic [BANK_W-1:0] opBank_r;
    logic              factoryMode_r;
    logic              factoryExit_r;
    logic [3:0]        errFlag;
    logic [3:0]        errSet;
    logic              anyErr;
    logic              startOk;

    assign anyErr = |errFlag;
    assign startOk = startReq.start && ctl_r == FOSR_IDLE && !anyErr
                     && !startReq.blockLocked && vppSync_r[1];
    assign opAccepted = startOk;
    assign opAbort = startReq.start && ctl_r == FOSR_IDLE && !startOk;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            ctl_r <= FOSR_IDLE;
        end else begin
            unique case (ctl_r)
                FOSR_IDLE: begin
                    if (startOk) begin
                        ctl_r <= FOSR_RUN;
                    end
                end
                FOSR_RUN: begin
                    if (engine.done) begin
                        ctl_r <= FOSR_IDLE;
                    end else if (suspendCmd && op_r != FOSR_OP_FACTORY) begin
                        ctl_r <= FOSR_SUSPENDING;
                    end
                end
                FOSR_SUSPENDING: begin
                    if (engine.done) begin
                        ctl_r <= FOSR_IDLE;
                    end else if (engine.paused) begin
                        ctl_r <= FOSR_SUSPENDED;
                    end
                end
                FOSR_SUSPENDED: begin
                    if (resumeCmd) begin
                        ctl_r <= FOSR_RUN;
                    end
                end
                default: ctl_r <= FOSR_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            op_r     <= FOSR_OP_PROGRAM;
            opBank_r <= '0;
        end else if (startOk) begin
            op_r     <= startReq.op;
            opBank_r <= startReq.bank;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            factoryMode_r <= 1'b0;
            factoryExit_r <= 1'b0;
        end else if (startOk) begin
            factoryMode_r <= startReq.op == FOSR_OP_FACTORY;
            factoryExit_r <= 1'b0;
        end else if (factoryMode_r && ctl_r == FOSR_RUN && engine.done) begin
            factoryExit_r <= 1'b1;
        end else if (factoryExit_r && startReq.start) begin
            factoryMode_r <= 1'b0;
            factoryExit_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Error flags.

    always_comb begin
        errSet = '0;
        errSet[3] = ctl_r != FOSR_IDLE && engine.done &&
                    ((op_r == FOSR_OP_ERASE && engine.pulseFail) ||
                     (op_r == FOSR_OP_BLANK && engine.notBlank));
        errSet[2] = ctl_r != FOSR_IDLE && engine.done &&
                    (op_r == FOSR_OP_PROGRAM || op_r == FOSR_OP_FACTORY) &&
                    (engine.pulseFail || engine.oneOverZero);
        errSet[1] = startReq.start && ctl_r == FOSR_IDLE && !anyErr &&
                    !vppSync_r[1];
        errSet[0] = startReq.start && ctl_r == FOSR_IDLE && !anyErr &&
                    vppSync_r[1] && startReq.blockLocked;
    end

    fosr_error_flags #(
        .WIDTH(4)
    ) u_errors (
        .clk     (clk),
        .resetn  (resetn),
        .setFlag (errSet),
        .clearAll(clearStatus),
        .flag_r  (errFlag)
    );

    ////////////////////////////////////////////////////////////////////////
    // Status byte and read path.

    logic ready;
    logic bankWrite;

    assign ready = ctl_r == FOSR_IDLE || ctl_r == FOSR_SUSPENDED;

    always_comb begin
        if (factoryMode_r) begin
            bankWrite = ready ? factoryExit_r
                              : (engine.bufferBusy || factoryExit_r);
        end else if (ready) begin
            bankWrite = 1'b0;
        end else begin
            bankWrite = opBank_r != readBank;
        end
    end

    assign statusNow = {ready,
                        ctl_r == FOSR_SUSPENDED && op_r != FOSR_OP_PROGRAM,
                        errFlag[3:1],
                        ctl_r == FOSR_SUSPENDED && op_r == FOSR_OP_PROGRAM,
                        errFlag[0],
                        bankWrite};

    assign statusSelected = !readArrayMode &&
                            ((ctl_r != FOSR_IDLE && readBank == opBank_r)
                             || factoryMode_r);

    always_ff @(posedge clk) begin
        if (!resetn) begin
            dataOut_r <= DOUT_RESET;
        end else if (!strobeN && strobeN_r) begin
            dataOut_r <= statusSelected ? {8'h00, statusNow} : arrayData;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    a_snap_hold: assert property (@(posedge clk) disable iff (!resetn)
        (!strobeN && !strobeN_r) |=> $stable(dataOut_r))
        else $error("Read data changed inside a strobe.");
    a_ready_idle: assert property (@(posedge clk) disable iff (!resetn)
        (ctl_r == FOSR_RUN) |-> !statusNow[BIT_READY])
        else $error("Ready shown while running.");
    a_suspend_wait: assert property (@(posedge clk) disable iff (!resetn)
        (ctl_r == FOSR_SUSPENDING && !engine.paused && !engine.done)
        |=> !statusNow[BIT_READY])
        else $error("Ready before pause.");
    a_resume_clear: assert property (@(posedge clk) disable iff (!resetn)
        (ctl_r == FOSR_SUSPENDED && resumeCmd) |=> !statusNow[BIT_ESUSP]
        && !statusNow[BIT_PSUSP])
        else $error("Suspend flag kept after resume.");
    a_no_illegal: assert property (@(posedge clk) disable iff (!resetn)
        !factoryMode_r |-> !(statusNow[BIT_READY] && statusNow[BIT_BANKW]))
        else $error("Ready with bank write outside factory.");
    a_blocked_start: assert property (@(posedge clk) disable iff (!resetn)
        anyErr |-> !opAccepted)
        else $error("Start accepted with error set.");
    a_protect_set: assert property (@(posedge clk) disable iff (!resetn)
        (startReq.start && ctl_r == FOSR_IDLE && !anyErr && vppSync_r[1]
         && startReq.blockLocked) |=> statusNow[BIT_PROT] ##1 ctl_r == FOSR_IDLE)
        else $error("Protected target not flagged.");
    a_supply_set: assert property (@(posedge clk) disable iff (!resetn)
        (startReq.start && ctl_r == FOSR_IDLE && !anyErr && !vppSync_r[1])
        |=> statusNow[BIT_SUPPLY] && ctl_r == FOSR_IDLE)
        else $error("Supply error not flagged.");
    a_other_bank: assert property (@(posedge clk) disable iff (!resetn)
        (!factoryMode_r && ctl_r == FOSR_RUN)
        |-> statusNow[BIT_BANKW] == (opBank_r != readBank))
        else $error("Bank write flag wrong.");

    c_suspend: cover property (@(posedge clk) ctl_r == FOSR_SUSPENDED);
    c_protect: cover property (@(posedge clk) statusNow[BIT_PROT]);
    c_factory: cover property (@(posedge clk) factoryExit_r);
    c_early_done: cover property (@(posedge clk)
        ctl_r == FOSR_SUSPENDING && engine.done);
    c_read: cover property (@(posedge clk) !strobeN && strobeN_r
        && statusSelected);

endmodule

// ===== tb/fosr_host_model.sv
// Host model that reads the status word over the flash bus.
`timescale 1ns/100ps
module fosr_host_model
    import fosr_pkg::*;
(
    input  wire logic              clk,
    input  wire logic [DATA_W-1:0] dataOut_r,
    output logic                   chipEnableN,
    output logic                   outputEnableN,
    output logic      [BANK_W-1:0] readBank
);
    initial begin
        chipEnableN = 1'b1;
        outputEnableN = 1'b1;
        readBank = 4'h0;
    end

    task automatic strobeDown(input logic [BANK_W-1:0] bk);
        repeat (2) @(posedge clk);
        chipEnableN <= 1'b0;
        outputEnableN <= 1'b0;
        readBank <= bk;
    endtask

    task automatic strobeUp(input int n, output logic [DATA_W-1:0] d);
        repeat (n) @(posedge clk);
        d = dataOut_r;
        chipEnableN <= 1'b1;
        outputEnableN <= 1'b1;
        readBank <= ~readBank;
    endtask
endmodule

// ===== tb/fosr_status_reg_tb.sv
// Self-checking bench for the flash operation status register.
`timescale 1ns/100ps
module fosr_status_reg_tb
    import fosr_pkg::*;
;
    logic              clk = 1'b0;
    logic              resetn = 1'b0;
    logic              supplyValid = 1'b1;
    logic              clearStatus = 1'b0;
    logic              suspendCmd = 1'b0;
    logic              resumeCmd = 1'b0;
    logic              readArrayMode = 1'b0;
    fosr_start_s       startReq = '0;
    fosr_engine_s      engine = '0;
    logic [DATA_W-1:0] arrayData = 16'h0000;
    logic              chipEnableN;
    logic              outputEnableN;
    logic [BANK_W-1:0] readBank;
    logic [DATA_W-1:0] dataOut_r;
    logic [DATA_W-1:0] rd;
    logic              statusSelected;
    logic              opAccepted;
    logic              opAbort;
    logic [SR_W-1:0]   statusNow;
    logic [3:0]        eErr = 4'h0;
    logic [BANK_W-1:0] b = 4'h0;
    logic              f;
    fosr_op_e          op;
    int                n_errors = 0;
    int                num_checks = 0;
    int                cyc = 0;

    always #5 clk = ~clk;

    fosr_status_reg dut_u (
        .clk(clk), .resetn(resetn), .chipEnableN(chipEnableN),
        .outputEnableN(outputEnableN), .readBank(readBank),
        .readArrayMode(readArrayMode), .supplyValid(supplyValid),
        .clearStatus(clearStatus), .suspendCmd(suspendCmd),
        .resumeCmd(resumeCmd), .startReq(startReq), .engine(engine),
        .arrayData(arrayData), .dataOut_r(dataOut_r),
        .statusSelected(statusSelected), .opAccepted(opAccepted),
        .opAbort(opAbort), .statusNow(statusNow)
    );

    fosr_host_model host_u (
        .clk(clk), .dataOut_r(dataOut_r), .chipEnableN(chipEnableN),
        .outputEnableN(outputEnableN), .readBank(readBank)
    );

    ////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    function automatic logic [7:0] sr(logic r, logic es, logic ps,
                                      logic bw);
        return {r, es, eErr[3:1], ps, eErr[0], bw};
    endfunction

    task automatic start(fosr_op_e o, logic lk, logic acc);
        @(posedge clk);
        startReq <= fosr_start_s'{1'b1, o, b, lk};
        #1 check(opAccepted, acc);
        check(opAbort, !acc);
        @(posedge clk);
        startReq.start <= 1'b0;
        #1;
    endtask

    task automatic fin(logic pf, logic nb, logic oz);
        @(posedge clk);
        engine <= fosr_engine_s'{1'b1, pf, nb, oz, 1'b0, 1'b0};
        @(posedge clk);
        engine <= '0;
        #1;
    endtask

    task automatic clr();
        @(posedge clk);
        clearStatus <= 1'b1;
        @(posedge clk);
        clearStatus <= 1'b0;
        eErr = 4'h0;
        #1 check(statusNow, sr(1, 0, 0, 0));
    endtask

    ////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            conclude();
        end
    end

    initial begin
        void'($urandom(6881));
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        #1 check(statusNow, 8'h80);
        for (int i = 0; i < 9; i++) begin
            op = fosr_op_e'(i % 3);
            b = BANK_W'($urandom);
            f = 1'($urandom);
            arrayData <= 16'($urandom);
            start(op, 1'b0, 1'b1);
            check(statusNow, sr(0, 0, 0, readBank != b));
            host_u.strobeDown(b);
            #1 check(statusSelected, 1'b1);
            check(statusNow, sr(0, 0, 0, 0));
            host_u.strobeUp(4, rd);
            check(rd, {8'h00, sr(0, 0, 0, 0)});
            readArrayMode <= 1'b1;
            host_u.strobeDown(b);
            #1 check(statusSelected, 1'b0);
            host_u.strobeUp(4, rd);
            check(rd, arrayData);
            readArrayMode <= 1'b0;
            if (op != FOSR_OP_BLANK) begin
                @(posedge clk);
                suspendCmd <= 1'b1;
                @(posedge clk);
                suspendCmd <= 1'b0;
                repeat (2) @(posedge clk);
                #1 check(statusNow[7], 1'b0);
                @(posedge clk);
                engine.paused <= 1'b1;
                @(posedge clk);
                #1 check(statusNow, sr(1, op == FOSR_OP_ERASE,
                                       op == FOSR_OP_PROGRAM, 0));
                @(posedge clk);
                resumeCmd <= 1'b1;
                engine.paused <= 1'b0;
                @(posedge clk);
                resumeCmd <= 1'b0;
                #1 check(statusNow, sr(0, 0, 0, 1));
            end
            fin(f & (op != FOSR_OP_BLANK), f & (op == FOSR_OP_BLANK), 0);
            if (f) eErr = (op == FOSR_OP_PROGRAM) ? 4'h4 : 4'h8;
            check(statusNow, sr(1, 0, 0, 0));
            if (f) begin
                start(op, 1'b0, 1'b0);
                check(statusNow, sr(1, 0, 0, 0));
                clr();
            end
        end
        start(FOSR_OP_PROGRAM, 1'b0, 1'b1);
        fin(0, 0, 1);
        eErr = 4'h4;
        check(statusNow, sr(1, 0, 0, 0));
        clr();
        start(FOSR_OP_ERASE, 1'b1, 1'b0);
        eErr = 4'h1;
        check(statusNow, sr(1, 0, 0, 0));
        clr();
        @(posedge clk);
        supplyValid <= 1'b0;
        repeat (3) @(posedge clk);
        start(FOSR_OP_ERASE, 1'b0, 1'b0);
        eErr = 4'h2;
        check(statusNow, sr(1, 0, 0, 0));
        @(posedge clk);
        supplyValid <= 1'b1;
        repeat (3) @(posedge clk);
        start(FOSR_OP_PROGRAM, 1'b0, 1'b0);
        clr();
        start(FOSR_OP_ERASE, 1'b0, 1'b1);
        @(posedge clk);
        suspendCmd <= 1'b1;
        @(posedge clk);
        suspendCmd <= 1'b0;
        fin(0, 0, 0);
        check(statusNow, sr(1, 0, 0, 0));
        start(FOSR_OP_FACTORY, 1'b0, 1'b1);
        host_u.strobeDown(b);
        #1 check(statusNow, sr(0, 0, 0, 0));
        repeat (4) @(posedge clk);
        engine.bufferBusy <= 1'b1;
        @(posedge clk);
        #1 check(statusNow, sr(0, 0, 0, 1));
        host_u.strobeUp(1, rd);
        check(rd, {8'h00, sr(0, 0, 0, 0)});
        fin(0, 0, 0);
        check(statusNow, sr(1, 0, 0, 1));
        start(FOSR_OP_PROGRAM, 1'b0, 1'b1);
        fin(0, 0, 0);
        check(statusNow, sr(1, 0, 0, 0));
        conclude();
    end
endmodule
